// >>> atc_pkg.sv
// package for the asynchronous 8-bit timer control block
// assumes one 125 MHz clock and a 32-bit ahb-lite register bus
package atc_pkg;
	// register byte offsets
	localparam logic [7:0] OFS_COUNT = 8'h00;
	localparam logic [7:0] OFS_CTL_A = 8'h04;
	localparam logic [7:0] OFS_CTL_B = 8'h08;
	localparam logic [7:0] OFS_COMPARE = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_MASK = 8'h14;
	localparam logic [7:0] OFS_FLAGS = 8'h18;
	localparam logic [7:0] OFS_GTC = 8'h1C;
	// index of the four buffered registers
	localparam int IDX_COUNT = 0;
	localparam int IDX_COMPARE = 1;
	localparam int IDX_CTL_A = 2;
	localparam int IDX_CTL_B = 3;
	// writable bits of each buffered register
	localparam logic [7:0] REG_MASK [4] = '{8'hFF, 8'hFF, 8'hC3, 8'h07};
	localparam logic [7:0] REG_RESET = 8'h00;
	// field positions
	localparam int STAT_EXT_CLOCK_INPUT_EN_BIT = 6;
	localparam int STAT_AS0_BIT = 5;
	localparam int IRQ_CMP_BIT = 1;
	localparam int IRQ_OVF_BIT = 0;
	localparam int GTC_TSM_BIT = 7;
	localparam int GTC_PRESCALER_RESET_8BIT_BIT = 1;
	localparam int GTC_PRESCALER_RESET_16BIT_BIT = 0;
	// counter values and clock selects
	localparam logic [7:0] CNT_MAX = 8'hFF;
	localparam logic [7:0] CNT_BOTTOM = 8'h00;
	localparam logic [2:0] CS_STOP = 3'h0;
	localparam logic [2:0] CS_DIRECT = 3'h1;
	localparam logic [2:0] CS_FIRST_TAP = 3'h2;
	// prescaler taps as powers of two
	localparam int PRE_BITS = 10;
	localparam int TAP0_LOG2 [6] = '{3, 5, 6, 7, 8, 10};
	localparam int TAP16_LOG2 [4] = '{3, 6, 8, 10};
	// waveform generation modes
	typedef enum logic [1:0] {
		ATC_WGM_NORMAL = 2'b00,
		ATC_WGM_PHASE = 2'b01,
		ATC_WGM_CTC = 2'b10,
		ATC_WGM_FAST = 2'b11
	} atc_wgm_t;
	// one bit per interrupt source
	typedef struct packed {
		logic compare;
		logic overflow;
	} atc_irq_t;
endpackage

// >>> atc_async_timer0.sv
// asynchronous 8-bit timer control: registers, busy handshake, flags, prescalers
// assumes an ahb-lite master with single word transfers; crystal pin is a plain input
// What this block does
// - counter always compared with compare value; equality drives flag and waveform, except on the tick after a counter write
// - external clock buffer on when enable and async set; oscillator only when clear
// - async select zero uses the io clock, one uses the crystal pin
// - async select stays one only with rc or watchdog system clock
// - async writes to the four buffered registers set their busy flag
// - counter reads live value; compare and controls read their temporary copy
// - interrupt request needs enable, global bit and flag all set
// - compare flag set on match, cleared by vector or writing one
// - overflow flag set on overflow, cleared by vector or writing one
// - phase correct mode sets overflow when turning around at bottom
// - writing one resets the prescaler, bit clears itself right after
// - in async mode the reset bit stays until the async reset happens
// - synchronization mode keeps the prescaler reset bits set
// - 16-bit timer prescaler gives taps of 8, 64, 256 and 1024
// - prescaler runs freely, independent of clock select
// - a shared prescaler reset restarts every timer connected to it
// - reserved bits of status, mask and flag registers read zero
// - leaving synchronization mode clears both prescaler reset bits
//
// Decided for this implementation: the AHB-Lite interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module atc_async_timer0 (
	// clock and reset
	input wire logic clock,
	input wire logic rst_b,
	// ahb-lite slave
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// system context
	input wire logic sysclk_from_rc_or_wdt,
	input wire logic cpu_status_global_irq,
	input wire logic cmp_vector_ack,
	input wire logic ovf_vector_ack,
	// crystal or external clock pin
	input wire logic crystal_input_pin,
	output logic ext_clock_buffer_en,
	output logic crystal_osc_en,
	// timer outputs
	output logic waveform_out_pin,
	output logic waveform_out_en,
	output logic compare_irq_req,
	output logic overflow_irq_req,
	output logic [3:0] prescale16_tick,
	output logic prescaler16_reset
);
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rst_b);

	logic wr_pend_r, rd_wait_r, in_map_r;
	logic [7:0] addr_r;
	logic [31:0] hrdata_r;
	logic [7:0] rd_val;
	logic as0_r, ext_clock_input_en_r, tsm_r, prescaler_reset_8bit_r, prescaler_reset_16bit_r;
	logic xs1_r, xs2_r, xs3_r;
	logic [9:0] pre0_r, pre16_r;
	logic [7:0] cnt_r, cmp_r, cta_r, ctb_r, cnt_nxt;
	logic dir_r, dir_nxt, wave_r, wave_nxt, cmp_block_r;
	atc_pkg::atc_irq_t flag_r, ien_r;
	atc_pkg::atc_wgm_t wgm;

	// address phase decode; hsize ignored, only whole words are used
	wire addr_ok = hsel & htrans[1] & hready;
	wire map_hit = (haddr[31:8] == 24'h000000) & (haddr[1:0] == 2'h0);
	wire [7:0] wd = hwdata[7:0];
	wire wr_now = wr_pend_r & in_map_r;
	wire wr_status = wr_now & (addr_r == atc_pkg::OFS_STATUS);
	wire wr_mask = wr_now & (addr_r == atc_pkg::OFS_MASK);
	wire wr_flags = wr_now & (addr_r == atc_pkg::OFS_FLAGS);
	wire wr_gtc = wr_now & (addr_r == atc_pkg::OFS_GTC);
	wire [3:0] wr_hit = {wr_now & (addr_r == atc_pkg::OFS_CTL_B),
		wr_now & (addr_r == atc_pkg::OFS_CTL_A),
		wr_now & (addr_r == atc_pkg::OFS_COMPARE),
		wr_now & (addr_r == atc_pkg::OFS_COUNT)};
	// reads take one wait state so a write just before is visible
	assign hreadyout = ~rd_wait_r;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	// bus phase tracking
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			wr_pend_r <= 1'b0;
			rd_wait_r <= 1'b0;
			in_map_r <= 1'b0;
			addr_r <= 8'h00;
			hrdata_r <= 32'h00000000;
		end
		else
		begin
			wr_pend_r <= addr_ok & hwrite;
			rd_wait_r <= addr_ok & ~hwrite;
			if (addr_ok)
			begin
				addr_r <= haddr[7:0];
				in_map_r <= map_hit;
			end
			if (rd_wait_r)
				hrdata_r <= {24'h000000, in_map_r ? rd_val : 8'h00};
		end
	end

	// pin synchroniser: the second and third stages feed the edge detector
	// three-stage synchroniser
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			xs1_r <= 1'b0;
			xs2_r <= 1'b0;
			xs3_r <= 1'b0;
		end
		else
		begin
			xs1_r <= crystal_input_pin;
			xs2_r <= xs1_r;
			xs3_r <= xs2_r;
		end
	end
	wire base_tick = as0_r ? (xs2_r & ~xs3_r) : 1'b1;

	// buffered registers: temporary copy, busy flag and load strobe each
	wire [3:0][7:0] tmp_v, ld_val;
	wire [3:0] busy_v, load_v;
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++)
		begin : g_buf
			logic [7:0] tmp_r;
			logic busy_r;
			always_ff @(posedge clock or negedge rst_b)
			begin
				if (!rst_b)
				begin
					tmp_r <= atc_pkg::REG_RESET;
					busy_r <= 1'b0;
				end
				else
				begin
					if (wr_hit[gi])
						tmp_r <= wd & atc_pkg::REG_MASK[gi];
					if (wr_hit[gi] & as0_r)
						busy_r <= 1'b1;
					else if (base_tick)
						busy_r <= 1'b0;
				end
			end
			assign tmp_v[gi] = tmp_r;
			assign busy_v[gi] = busy_r;
			assign load_v[gi] = as0_r ? (busy_r & base_tick) : wr_hit[gi];
			assign ld_val[gi] = as0_r ? tmp_r : (wd & atc_pkg::REG_MASK[gi]);
		end
	endgenerate

	// live compare and control registers
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cmp_r <= atc_pkg::REG_RESET;
			cta_r <= atc_pkg::REG_RESET;
			ctb_r <= atc_pkg::REG_RESET;
		end
		else
		begin
			if (load_v[atc_pkg::IDX_COMPARE])
				cmp_r <= ld_val[atc_pkg::IDX_COMPARE];
			if (load_v[atc_pkg::IDX_CTL_A])
				cta_r <= ld_val[atc_pkg::IDX_CTL_A];
			if (load_v[atc_pkg::IDX_CTL_B])
				ctb_r <= ld_val[atc_pkg::IDX_CTL_B];
		end
	end

	// status and gtc bits; as0 drops whenever the system clock is unsuitable
	// async select forced low
	wire as0_nxt = wr_status ? (wd[atc_pkg::STAT_AS0_BIT] & sysclk_from_rc_or_wdt)
		: (as0_r & sysclk_from_rc_or_wdt);
	wire gtc_keep = wd[atc_pkg::GTC_TSM_BIT] | ~tsm_r;
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			as0_r <= 1'b0;
			ext_clock_input_en_r <= 1'b0;
			tsm_r <= 1'b0;
			prescaler_reset_8bit_r <= 1'b0;
			prescaler_reset_16bit_r <= 1'b0;
		end
		else
		begin
			as0_r <= as0_nxt;
			if (wr_status)
				ext_clock_input_en_r <= wd[atc_pkg::STAT_EXT_CLOCK_INPUT_EN_BIT];
			if (wr_gtc)
			begin
				tsm_r <= wd[atc_pkg::GTC_TSM_BIT];
				prescaler_reset_8bit_r <= wd[atc_pkg::GTC_PRESCALER_RESET_8BIT_BIT] | (prescaler_reset_8bit_r & gtc_keep);
				prescaler_reset_16bit_r <= wd[atc_pkg::GTC_PRESCALER_RESET_16BIT_BIT] | (prescaler_reset_16bit_r & gtc_keep);
			end
			else
			begin
				if (base_tick & ~tsm_r)
					prescaler_reset_8bit_r <= 1'b0;
				if (~tsm_r)
					prescaler_reset_16bit_r <= 1'b0;
			end
		end
	end
	assign ext_clock_buffer_en = ext_clock_input_en_r & as0_r;
	assign crystal_osc_en = as0_r & ~ext_clock_input_en_r;

	// free-running prescalers, held at zero only by their reset bits
	// free run and reset
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			pre0_r <= 10'h000;
			pre16_r <= 10'h000;
		end
		else
		begin
			if (base_tick)
				pre0_r <= prescaler_reset_8bit_r ? 10'h000 : pre0_r + 10'h001;
			pre16_r <= prescaler_reset_16bit_r ? 10'h000 : pre16_r + 10'h001;
		end
	end
	// tap decode: a tap fires as its low bits roll over
	wire [5:0] tap0;
	genvar ti;
	generate
		for (ti = 0; ti < 6; ti++)
		begin : g_tap0
			localparam int L = atc_pkg::TAP0_LOG2[ti];
			assign tap0[ti] = base_tick & ~prescaler_reset_8bit_r & (&pre0_r[L-1:0]);
		end
		for (ti = 0; ti < 4; ti++)
		begin : g_tap16
			localparam int L = atc_pkg::TAP16_LOG2[ti];
			assign prescale16_tick[ti] = ~prescaler_reset_16bit_r & (&pre16_r[L-1:0]);
		end
	endgenerate
	// every timer on the 16-bit prescaler sees its reset
	assign prescaler16_reset = prescaler_reset_16bit_r;

	// timer clock select from the live control b
	wire [2:0] cs = ctb_r[2:0];
	wire [2:0] tap_idx = cs - atc_pkg::CS_FIRST_TAP;
	wire tick = (cs == atc_pkg::CS_STOP) ? 1'b0
		: (cs == atc_pkg::CS_DIRECT) ? base_tick : tap0[tap_idx];
	assign wgm = atc_pkg::atc_wgm_t'(cta_r[1:0]);
	wire [1:0] com = cta_r[7:6];
	wire [7:0] top = (wgm == atc_pkg::ATC_WGM_CTC) ? cmp_r : atc_pkg::CNT_MAX;
	// continuous equality compare; a counter write masks one match
	wire match_ev = tick & (cnt_r == cmp_r) & ~cmp_block_r;
	wire ovf_ev = tick & ((wgm == atc_pkg::ATC_WGM_PHASE)
		? (dir_r & (cnt_r == atc_pkg::CNT_BOTTOM)) : (cnt_r == atc_pkg::CNT_MAX));

	// counting sequence
	always_comb
	begin
		cnt_nxt = cnt_r + 8'h01;
		dir_nxt = dir_r;
		if (wgm == atc_pkg::ATC_WGM_PHASE)
		begin
			if (dir_r & (cnt_r == atc_pkg::CNT_BOTTOM))
				dir_nxt = 1'b0;
			else if (~dir_r & (cnt_r == atc_pkg::CNT_MAX))
				dir_nxt = 1'b1;
			if (dir_nxt)
				cnt_nxt = cnt_r - 8'h01;
		end
		else if (cnt_r == top)
			cnt_nxt = atc_pkg::CNT_BOTTOM;
	end

	// waveform output per mode and compare output setting
	always_comb
	begin
		wave_nxt = wave_r;
		unique case (wgm)
			atc_pkg::ATC_WGM_NORMAL, atc_pkg::ATC_WGM_CTC:
				if (match_ev & (com != 2'b00))
					wave_nxt = (com == 2'b01) ? ~wave_r : com[0];
			atc_pkg::ATC_WGM_FAST:
				if (com[1] & match_ev)
					wave_nxt = com[0];
				else if (com[1] & tick & (cnt_r == atc_pkg::CNT_MAX))
					wave_nxt = ~com[0];
			atc_pkg::ATC_WGM_PHASE:
				if (com[1] & match_ev)
					wave_nxt = com[0] ^ dir_r;
		endcase
	end
	// pwm modes leave the pin to the port for setting 01
	assign waveform_out_en = (com != 2'b00) & ~(wgm[0] & ~com[1]);
	assign waveform_out_pin = wave_r;

	// counter, direction, waveform and flags
	always_ff @(posedge clock or negedge rst_b)
	begin
		if (!rst_b)
		begin
			cnt_r <= atc_pkg::REG_RESET;
			dir_r <= 1'b0;
			wave_r <= 1'b0;
			cmp_block_r <= 1'b0;
			flag_r <= '0;
			ien_r <= '0;
		end
		else
		begin
			if (load_v[atc_pkg::IDX_COUNT])
				cnt_r <= ld_val[atc_pkg::IDX_COUNT];
			else if (tick)
				cnt_r <= cnt_nxt;
			if (tick)
				dir_r <= dir_nxt;
			wave_r <= wave_nxt;
			if (load_v[atc_pkg::IDX_COUNT])
				cmp_block_r <= 1'b1;
			else if (tick)
				cmp_block_r <= 1'b0;
			if (wr_mask)
				ien_r <= {wd[atc_pkg::IRQ_CMP_BIT], wd[atc_pkg::IRQ_OVF_BIT]};
			flag_r.compare <= match_ev | (flag_r.compare & ~cmp_vector_ack
				& ~(wr_flags & wd[atc_pkg::IRQ_CMP_BIT]));
			flag_r.overflow <= ovf_ev | (flag_r.overflow & ~ovf_vector_ack
				& ~(wr_flags & wd[atc_pkg::IRQ_OVF_BIT]));
		end
	end
	assign compare_irq_req = ien_r.compare & cpu_status_global_irq & flag_r.compare;
	assign overflow_irq_req = ien_r.overflow & cpu_status_global_irq & flag_r.overflow;

	// read mux; live counter, temporary copies for compare and controls
	// reserved bits read zero
	always_comb
	begin
		unique case (addr_r)
			atc_pkg::OFS_COUNT: rd_val = cnt_r;
			atc_pkg::OFS_COMPARE: rd_val = tmp_v[atc_pkg::IDX_COMPARE];
			atc_pkg::OFS_CTL_A: rd_val = tmp_v[atc_pkg::IDX_CTL_A];
			atc_pkg::OFS_CTL_B: rd_val = tmp_v[atc_pkg::IDX_CTL_B];
			atc_pkg::OFS_STATUS: rd_val = {1'b0, ext_clock_input_en_r, as0_r, busy_v[0], busy_v[1], 1'b0,
				busy_v[2], busy_v[3]};
			atc_pkg::OFS_MASK: rd_val = {6'h00, ien_r};
			atc_pkg::OFS_FLAGS: rd_val = {6'h00, flag_r};
			atc_pkg::OFS_GTC: rd_val = {tsm_r, 5'h00, prescaler_reset_8bit_r, prescaler_reset_16bit_r};
			default: rd_val = 8'h00;
		endcase
	end

	// checks
	a_busy_on_write: assert property (wr_hit[0] & as0_r |=> busy_v[0])
		else $error("count busy not set by async write");
	a_busy_cleared_xfer: assert property (busy_v[1] & base_tick & ~wr_hit[1] |=> ~busy_v[1]
		&& cmp_r == $past(tmp_v[1]))
		else $error("compare transfer missing");
	a_cmp_flag_set: assert property (match_ev |=> flag_r.compare)
		else $error("compare flag not set on match");
	a_ovf_flag_set: assert property (ovf_ev |=> flag_r.overflow)
		else $error("overflow flag not set");
	a_phase_bottom_ovf: assert property (wgm == atc_pkg::ATC_WGM_PHASE && tick && dir_r
		&& cnt_r == 8'h00 && !load_v[0] |=> flag_r.overflow && cnt_r == 8'h01)
		else $error("phase correct bottom turn wrong");
	a_irq_follows_flag: assert property ($rose(flag_r.compare) && ien_r.compare
		&& cpu_status_global_irq |-> compare_irq_req)
		else $error("compare request not raised");
	a_psr_held_tsm: assert property (tsm_r && prescaler_reset_8bit_r && !wr_gtc |=> prescaler_reset_8bit_r)
		else $error("prescaler reset released in sync mode");
	a_psr_async_wait: assert property (as0_r && prescaler_reset_8bit_r && !base_tick && !wr_gtc
		|=> prescaler_reset_8bit_r)
		else $error("async prescaler reset ended early");
	a_tsm_release: assert property (wr_gtc && tsm_r && wd == 8'h00
		|=> !prescaler_reset_8bit_r && !prescaler_reset_16bit_r && !tsm_r)
		else $error("tsm release left resets set");
	a_as0_forced_low: assert property (!sysclk_from_rc_or_wdt |=> !as0_r)
		else $error("async select kept without rc clock");
	a_ext_clock_input_en_buffer: assert property (ext_clock_buffer_en |-> as0_r && !crystal_osc_en)
		else $error("external clock buffer misgated");
	c_compare_match: cover property (match_ev ##1 compare_irq_req);
	c_async_transfer: cover property (busy_v[0] ##[1:40] !busy_v[0]);
	c_phase_ovf: cover property (wgm == atc_pkg::ATC_WGM_PHASE && ovf_ev);
	c_tsm_hold: cover property (tsm_r && prescaler_reset_8bit_r ##1 !tsm_r);
endmodule
`default_nettype wire

// >>> tb.sv
// self-checking bench for the asynchronous 8-bit timer control block
// assumes the block alone on an ahb-lite bus, hready fed back from hreadyout
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic clock;
	logic rst_b;
	logic hsel;
	logic [31:0] haddr;
	logic [1:0] htrans;
	logic hwrite;
	logic [31:0] hwdata;
	wire logic hready;
	logic hreadyout;
	logic hresp;
	logic [31:0] hrdata;
	logic sys_ok;
	logic gie;
	logic cmp_ack;
	logic ovf_ack;
	logic xtal;
	logic buf_en;
	logic osc_en;
	logic wave;
	logic wave_en;
	logic cmp_req;
	logic ovf_req;
	logic [3:0] tick16;
	logic pre16_rst;
	logic [31:0] rdat;
	int n_fail;
	int num_checks;
	int cycles;
	int per;
	// single slave, so its ready is the bus ready
	assign hready = hreadyout;
	atc_async_timer0 i_dut (.clock(clock), .rst_b(rst_b), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .sysclk_from_rc_or_wdt(sys_ok),
		.cpu_status_global_irq(gie), .cmp_vector_ack(cmp_ack), .ovf_vector_ack(ovf_ack),
		.crystal_input_pin(xtal), .ext_clock_buffer_en(buf_en), .crystal_osc_en(osc_en),
		.waveform_out_pin(wave), .waveform_out_en(wave_en), .compare_irq_req(cmp_req),
		.overflow_irq_req(ovf_req), .prescale16_tick(tick16), .prescaler16_reset(pre16_rst));
	// 125 MHz clock
	initial clock = 1'b0;
	always #4 clock = ~clock;
	// hang guard, far above the less than one thousand cycles the tests need
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 8000)
		begin
			n_fail++;
			$display("unexpected timeout: expected finish, seen hang");
			end_sim();
		end
	end
	task chk_reg(input string what, input logic [7:0] exp, input logic [7:0] got);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask
	task chk_bit(input string what, input logic exp, input logic got);
		num_checks++;
		if (got !== exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %b, seen %b", what, exp, got);
		end
	endtask
	task chk_cnt(input string what, input int exp, input int got);
		num_checks++;
		if (got != exp)
		begin
			n_fail++;
			$display("unexpected %s: expected %0d, seen %0d", what, exp, got);
		end
	endtask
	// ready is looked at mid-cycle, where the combinational value has settled
	task wait_ready;
		do
			@(negedge clock);
		while (hreadyout !== 1'b1);
		@(posedge clock);
	endtask
	// every transfer starts right after a rising edge, whatever the caller last waited for
	task xfer(input logic wr, input logic [7:0] adr, input logic [7:0] wd);
		@(posedge clock);
		hsel <= 1'b1;
		haddr <= {24'h000000, adr};
		htrans <= 2'b10;
		hwrite <= wr;
		wait_ready();
		htrans <= 2'b00;
		hwdata <= {24'h000000, wd};
		wait_ready();
		rdat = hrdata;
	endtask
	task wr(input logic [7:0] adr, input logic [7:0] wd);
		xfer(1'b1, adr, wd);
	endtask
	task rd(input string what, input logic [7:0] adr, input logic [7:0] exp);
		xfer(1'b0, adr, 8'h00);
		chk_reg(what, exp, rdat[7:0]);
		chk_reg("upper read bits", 8'h00, rdat[15:8]);
		chk_bit("response", 1'b0, hresp);
	endtask
	task done(input string name);
		$display("test %s finished", name);
	endtask
	// cycles from one tick of a prescaler tap to the next
	task period(input int idx, output int p);
		int i;
		p = 0;
		@(negedge clock);
		for (i = 0; i < 2100 && tick16[idx] !== 1'b1; i++)
			@(negedge clock);
		do
		begin
			@(negedge clock);
			p++;
		end
		while (tick16[idx] !== 1'b1 && p < 2100);
	endtask
	task t_reset;
		rd("count", atc_pkg::OFS_COUNT, 8'h00);
		rd("control a", atc_pkg::OFS_CTL_A, 8'h00);
		rd("control b", atc_pkg::OFS_CTL_B, 8'h00);
		rd("compare", atc_pkg::OFS_COMPARE, 8'h00);
		rd("status", atc_pkg::OFS_STATUS, 8'h00);
		rd("mask", atc_pkg::OFS_MASK, 8'h00);
		rd("flags", atc_pkg::OFS_FLAGS, 8'h00);
		rd("gtc", atc_pkg::OFS_GTC, 8'h00);
		chk_bit("osc enable", 1'b0, osc_en);
		done("reset");
	endtask
	task t_regs;
		wr(atc_pkg::OFS_COMPARE, 8'hA5);
		rd("compare", atc_pkg::OFS_COMPARE, 8'hA5);
		wr(atc_pkg::OFS_MASK, 8'hFF);
		rd("mask", atc_pkg::OFS_MASK, 8'h03);
		wr(atc_pkg::OFS_MASK, 8'h00);
		wr(atc_pkg::OFS_STATUS, 8'h9F);
		rd("status", atc_pkg::OFS_STATUS, 8'h00);
		wr(8'h40, 8'hFF);
		rd("unmapped", 8'h40, 8'h00);
		done("registers");
	endtask
	task t_overflow;
		int i;
		gie <= 1'b1;
		wr(atc_pkg::OFS_COUNT, 8'hF0);
		wr(atc_pkg::OFS_MASK, 8'h01);
		wr(atc_pkg::OFS_CTL_B, 8'h01);
		for (i = 0; i < 64 && ovf_req !== 1'b1; i++)
			@(negedge clock);
		chk_bit("overflow request", 1'b1, ovf_req);
		gie <= 1'b0;
		@(negedge clock);
		chk_bit("overflow request", 1'b0, ovf_req);
		wr(atc_pkg::OFS_CTL_B, 8'h00);
		xfer(1'b0, atc_pkg::OFS_FLAGS, 8'h00);
		chk_bit("overflow flag", 1'b1, rdat[0]);
		chk_reg("spare flags", 8'h00, rdat[7:0] & 8'hFC);
		wr(atc_pkg::OFS_FLAGS, 8'h01);
		xfer(1'b0, atc_pkg::OFS_FLAGS, 8'h00);
		chk_bit("overflow flag", 1'b0, rdat[0]);
		done("overflow");
	endtask
	task t_compare;
		int i;
		wr(atc_pkg::OFS_COUNT, 8'h70);
		wr(atc_pkg::OFS_COMPARE, 8'h80);
		wr(atc_pkg::OFS_MASK, 8'h02);
		gie <= 1'b1;
		wr(atc_pkg::OFS_CTL_B, 8'h01);
		for (i = 0; i < 64 && cmp_req !== 1'b1; i++)
			@(negedge clock);
		chk_bit("compare request", 1'b1, cmp_req);
		wr(atc_pkg::OFS_CTL_B, 8'h00);
		cmp_ack <= 1'b1;
		@(posedge clock);
		cmp_ack <= 1'b0;
		@(negedge clock);
		chk_bit("compare request", 1'b0, cmp_req);
		wr(atc_pkg::OFS_MASK, 8'h00);
		done("compare");
	endtask
	task t_async;
		sys_ok <= 1'b0;
		wr(atc_pkg::OFS_STATUS, 8'h20);
		rd("status", atc_pkg::OFS_STATUS, 8'h00);
		sys_ok <= 1'b1;
		wr(atc_pkg::OFS_STATUS, 8'h40);
		wr(atc_pkg::OFS_STATUS, 8'h60);
		@(negedge clock);
		chk_bit("buffer enable", 1'b1, buf_en);
		chk_bit("osc enable", 1'b0, osc_en);
		wr(atc_pkg::OFS_STATUS, 8'h20);
		@(negedge clock);
		chk_bit("buffer enable", 1'b0, buf_en);
		chk_bit("osc enable", 1'b1, osc_en);
		// one write only, no second write while busy
		wr(atc_pkg::OFS_COMPARE, 8'h5A);
		rd("status", atc_pkg::OFS_STATUS, 8'h28);
		rd("compare", atc_pkg::OFS_COMPARE, 8'h5A);
		wr(atc_pkg::OFS_GTC, 8'h02);
		rd("gtc", atc_pkg::OFS_GTC, 8'h02);
		// one slow clock edge carries the transfer across
		xtal <= 1'b1;
		repeat (6) @(posedge clock);
		xtal <= 1'b0;
		repeat (6) @(posedge clock);
		rd("status", atc_pkg::OFS_STATUS, 8'h20);
		rd("gtc", atc_pkg::OFS_GTC, 8'h00);
		sys_ok <= 1'b0;
		@(posedge clock);
		rd("status", atc_pkg::OFS_STATUS, 8'h00);
		sys_ok <= 1'b1;
		done("async");
	endtask
	task t_prescale;
		int i;
		int n;
		wr(atc_pkg::OFS_GTC, 8'h02);
		rd("gtc", atc_pkg::OFS_GTC, 8'h00);
		wr(atc_pkg::OFS_GTC, 8'h81);
		rd("gtc", atc_pkg::OFS_GTC, 8'h81);
		chk_bit("prescaler reset", 1'b1, pre16_rst);
		n = 0;
		for (i = 0; i < 32; i++)
		begin
			@(negedge clock);
			n += tick16[0];
		end
		chk_cnt("ticks in hold", 0, n);
		wr(atc_pkg::OFS_GTC, 8'h00);
		rd("gtc", atc_pkg::OFS_GTC, 8'h00);
		chk_bit("prescaler reset", 1'b0, pre16_rst);
		period(0, per);
		chk_cnt("tap 8 period", 8, per);
		period(1, per);
		chk_cnt("tap 64 period", 64, per);
		done("prescaler");
	endtask
	// phase correct: up from 0xfd, turn at top, overflow only at the bottom turn
	task t_phase;
		wr(atc_pkg::OFS_COUNT, 8'hFD);
		wr(atc_pkg::OFS_CTL_A, 8'h01);
		rd("control a", atc_pkg::OFS_CTL_A, 8'h01);
		wr(atc_pkg::OFS_CTL_B, 8'h01);
		repeat (300) @(posedge clock);
		wr(atc_pkg::OFS_CTL_B, 8'h00);
		xfer(1'b0, atc_pkg::OFS_FLAGS, 8'h00);
		chk_bit("phase overflow flag", 1'b1, rdat[0]);
		wr(atc_pkg::OFS_FLAGS, 8'h03);
		wr(atc_pkg::OFS_CTL_A, 8'h00);
		rd("flags", atc_pkg::OFS_FLAGS, 8'h00);
		done("phase");
	endtask
	task end_sim;
		$display("comparisons %0d, mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	// reset for ten cycles, then the tests in turn
	initial
	begin
		n_fail = 0;
		num_checks = 0;
		cycles = 0;
		rst_b = 1'b0;
		hsel = 1'b0;
		haddr = 32'h00000000;
		htrans = 2'b00;
		hwrite = 1'b0;
		hwdata = 32'h00000000;
		sys_ok = 1'b1;
		gie = 1'b0;
		cmp_ack = 1'b0;
		ovf_ack = 1'b0;
		xtal = 1'b0;
		repeat (10) @(posedge clock);
		rst_b <= 1'b1;
		@(posedge clock);
		t_reset();
		t_regs();
		t_overflow();
		t_compare();
		t_async();
		t_phase();
		t_prescale();
		end_sim();
	end
endmodule
`default_nettype wire
